// ===== rtl/psrc_cfg.svh
// constants of the power supervisor and regulator controller
`ifndef PSRC_CFG_SVH
`define PSRC_CFG_SVH
// register byte offsets
`define PSRC_OFF_MODE      8'h00
`define PSRC_OFF_INT       8'h04
`define PSRC_OFF_MASK      8'h08
`define PSRC_OFF_STATUS    8'h0C
// mode register fields
`define PSRC_MODE_DIS_BIT  0
`define PSRC_MODE_DCM_BIT  1
`define PSRC_MODE_PFM_BIT  2
`define PSRC_MODE_RST      3'h0
// interrupt and mask fields
`define PSRC_INT_MON_BIT   0
`define PSRC_INT_RST       1'h0
`define PSRC_MASK_RST      1'h0
// timing
`define PSRC_CLK_KHZ       125000
`define PSRC_REL_DELAY_US  4000
`define PSRC_REL_CYCLES    ((`PSRC_REL_DELAY_US * `PSRC_CLK_KHZ) / 1000)
// switching clock 1.229 MHz: half period in cycles, rounded down
`define PSRC_SW_HZ         1229000
`define PSRC_SW_HALF       ((`PSRC_CLK_KHZ * 1000) / (2 * `PSRC_SW_HZ))
`endif

// ===== rtl/psrc_pkg.sv
// types of the power supervisor and regulator controller
package psrc_pkg;
   typedef enum logic [1:0] {MODE_PWM, MODE_PFM, MODE_DCM, MODE_OFF}
      psrc_mode_t;
   typedef enum {ST_RESET, ST_WAIT, ST_RUN} psrc_state_t;
endpackage : psrc_pkg

// ===== rtl/psrc_ctrl.sv
// supervisor, reset line and buck regulator control with apb registers
`timescale 1ns/10ps
`include "psrc_cfg.svh"

module psrc_ctrl
   import psrc_pkg::*;
   #(
   parameter int unsigned REL_CYCLES = `PSRC_REL_CYCLES
   )
   (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        clkEn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // reset / power ok line, open drain
   input  wire logic        resetPowerOkLineIn,
   output logic             resetPowerOkLineOut,
   output logic             resetPowerOkLineOe,
   // analog comparator inputs
   input  wire logic        fieldSupplyOk,
   input  wire logic        fiveVoltRailOk,
   input  wire logic        outAbove95,
   input  wire logic        outAbove101,
   input  wire logic        outAbove103,
   input  wire logic        voltageMonitorLow,
   // regulator control, interrupt and chip reset
   output logic             regulatorEnable,
   output logic [1:0]       regulatorMode,
   output logic             switchNodeRun,
   output logic             switchClk,
   output logic             irq,
   output logic             chipReset
   );

   // two-flop synchronisers for all pin inputs
   logic [6:0] syncA_reg;
   logic [6:0] syncB_reg;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         syncA_reg <= 7'h00;
         syncB_reg <= 7'h00;
      end
      else if (clkEn)
      begin
         syncA_reg <= {resetPowerOkLineIn, fieldSupplyOk, fiveVoltRailOk,
                       outAbove95, outAbove101, outAbove103,
                       voltageMonitorLow};
         syncB_reg <= syncA_reg;
      end
   end
   logic lineHigh, v24Ok, v5Ok, ok95, ok101, ok103, monLow;
   assign {lineHigh, v24Ok, v5Ok, ok95, ok101, ok103, monLow} = syncB_reg;

   // registers and supervisor state
   logic [2:0]  mode_reg, mode_next;
   logic        monFlag_reg, monFlag_next;
   logic        mask_reg, mask_next;
   psrc_state_t state_reg, state_next;
   logic [31:0] cnt_reg, cnt_next;
   logic        soft_reg, soft_next;
   logic        pfmStop_reg, pfmStop_next;
   logic        drvLow_reg, drvLow_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        err_reg, err_next;
   logic        longWait_reg, longWait_next;

   logic access, wr, rd, suppliesOk, regOff, hit, held;
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   assign regOff = mode_reg[`PSRC_MODE_DIS_BIT];
   // buck below 95% only counts while regulator is on
   assign suppliesOk = v24Ok && v5Ok && (regOff || ok95);
   assign hit = (paddr == `PSRC_OFF_MODE) || (paddr == `PSRC_OFF_INT)
             || (paddr == `PSRC_OFF_MASK) || (paddr == `PSRC_OFF_STATUS);
   // line low while we do not pull it: someone outside holds it
   assign held = !lineHigh && !drvLow_reg;

   // next state of supervisor, registers and apb answer
   always_comb
   begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      mode_next    = mode_reg;
      mask_next    = mask_reg;
      monFlag_next = monFlag_reg;
      soft_next    = soft_reg;
      pfmStop_next = pfmStop_reg;
      rdata_next   = rdata_reg;
      err_next     = 1'b0;
      longWait_next = longWait_reg;
      drvLow_next   = drvLow_reg;
      // run is entered only once the line is seen high, so the
      // synchroniser delay after our own release is never taken
      // for an outside reset
      unique case (state_reg)
         ST_RESET:
         begin
            // undervoltage keeps the line pulled low
            drvLow_next = 1'b1;
            if (suppliesOk)
            begin
               state_next = ST_WAIT;
               cnt_next   = 32'h0000_0000;
            end
         end
         ST_WAIT:
         begin
            if (!suppliesOk)
            begin
               // any invalid supply restarts the count
               state_next    = ST_RESET;
               longWait_next = 1'b1;
               drvLow_next   = 1'b1;
            end
            else if (drvLow_reg)
            begin
               // release at once, or after the delay if longWait_reg is set, with supplies valid
               if (!longWait_reg || cnt_reg >= REL_CYCLES - 1)
               begin
                  longWait_next = 1'b0;
                  drvLow_next   = 1'b0;
               end
               else
                  cnt_next = cnt_reg + 32'h0000_0001;
            end
            else if (lineHigh)
            begin
               // disabled regulator waits the full delay
               // limitation: the released line is free for a few
               // cycles before we pull it again for the delay
               if (longWait_reg)
               begin
                  cnt_next    = 32'h0000_0000;
                  drvLow_next = 1'b1;
               end
               else
                  state_next = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (!suppliesOk)
            begin
               state_next    = ST_RESET;
               longWait_next = 1'b1;
               drvLow_next   = 1'b1;
            end
            else if (held)
            begin
               // external low line forces wait state and chip reset
               state_next    = ST_WAIT;
               longWait_next = regOff;
            end
         end
      endcase
      // soft start ends when the output reaches 95%
      if (!v24Ok || regOff)
         soft_next = 1'b1;
      else if (ok95)
         soft_next = 1'b0;
      // pfm hysteresis between 103% and 101%
      if (ok103)
         pfmStop_next = 1'b1;
      else if (!ok101)
         pfmStop_next = 1'b0;
      // reads and errors answer in every state; writes outside run are overridden by the reset defaults
      if (rd)
      begin
         rdata_next = 32'h0000_0000;
         unique case (paddr)
            `PSRC_OFF_MODE:   rdata_next[2:0] = mode_reg;
            `PSRC_OFF_INT:    rdata_next[0] = monFlag_reg;
            `PSRC_OFF_MASK:   rdata_next[0] = mask_reg;
            `PSRC_OFF_STATUS: rdata_next[3:0] = {soft_reg, monLow,
                                                 suppliesOk, chipReset};
            default:          rdata_next = 32'h0000_0000;
         endcase
      end
      err_next = access && !hit;
      if (wr && paddr == `PSRC_OFF_MODE)
         mode_next = pwdata[2:0];
      if (wr && paddr == `PSRC_OFF_MASK)
         mask_next = pwdata[0];
      // read clears only with the input above threshold
      // write one also clears a gone cause
      if (((rd && paddr == `PSRC_OFF_INT)
           || (wr && paddr == `PSRC_OFF_INT && pwdata[0])) && !monLow)
         monFlag_next = 1'b0;
      // low monitor sets the flag, set wins
      if (monLow)
         monFlag_next = 1'b1;
      // held in reset, registers return to defaults
      if (state_reg != ST_RUN || held)
      begin
         mode_next    = `PSRC_MODE_RST;
         mask_next    = `PSRC_MASK_RST;
         monFlag_next = `PSRC_INT_RST;
      end
   end

   // register stage
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg   <= ST_RESET;
         cnt_reg     <= 32'h0000_0000;
         mode_reg    <= `PSRC_MODE_RST;
         mask_reg    <= `PSRC_MASK_RST;
         monFlag_reg <= `PSRC_INT_RST;
         soft_reg    <= 1'b1;
         pfmStop_reg <= 1'b0;
         drvLow_reg  <= 1'b1;
         longWait_reg <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         err_reg     <= 1'b0;
      end
      else if (clkEn)
      begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         mode_reg    <= mode_next;
         mask_reg    <= mask_next;
         monFlag_reg <= monFlag_next;
         soft_reg    <= soft_next;
         pfmStop_reg <= pfmStop_next;
         drvLow_reg  <= drvLow_next;
         longWait_reg <= longWait_next;
         rdata_reg   <= rdata_next;
         err_reg     <= err_next;
      end
   end

   // switching clock divider
   logic [7:0] div_reg, div_next;
   logic       sw_reg, sw_next;
   always_comb
   begin
      div_next = div_reg + 8'h01;
      sw_next  = sw_reg;
      // toggle each half period of 1.229 MHz
      if (div_reg >= 8'(`PSRC_SW_HALF - 1))
      begin
         div_next = 8'h00;
         sw_next  = !sw_reg;
      end
   end
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_reg <= 8'h00;
         sw_reg  <= 1'b0;
      end
      else if (clkEn)
      begin
         div_reg <= div_next;
         sw_reg  <= sw_next;
      end
   end

   // outputs; pready fixed high, answer registered one cycle after the access
   assign pready  = 1'b1;
   assign prdata  = rdata_reg;
   assign pslverr = err_reg;
   assign resetPowerOkLineOut = 1'b0;
   // enable low means the pin is pulled low
   assign resetPowerOkLineOe = !drvLow_reg;
   assign chipReset = state_reg != ST_RUN;
   // disable bit turns the regulator off
   assign regulatorEnable = !regOff && v24Ok;
   // unmasked flag drives the level interrupt
   assign irq = monFlag_reg && !mask_reg;
   // dcm over pfm over pwm; dcm in soft start
   assign regulatorMode = !regulatorEnable ? MODE_OFF
      : (soft_reg || mode_reg[`PSRC_MODE_DCM_BIT]) ? MODE_DCM
      : mode_reg[`PSRC_MODE_PFM_BIT] ? MODE_PFM : MODE_PWM;
   assign switchNodeRun = regulatorEnable
      && !(regulatorMode == MODE_PFM && pfmStop_reg);
   assign switchClk = sw_reg && switchNodeRun;

endmodule : psrc_ctrl

// ===== tb/psrc_host.sv
// host side of the open-drain reset line, pull-up included
`timescale 1ns/10ps
module psrc_host
   (
   // device pin and host pull request
   input  wire logic devOut,
   input  wire logic devOe,
   input  wire logic hostPull,
   // resolved level seen by everyone
   output logic      lineLevel
   );
   // pull only
   // host can only sink; the pull-up makes the high level
   assign lineLevel = !hostPull && (devOe || devOut);
endmodule : psrc_host

// ===== tb/psrc_ctrl_props.sv
// port assertions and covers of the regulator controller
`timescale 1ns/10ps
`include "psrc_cfg.svh"
module psrc_ctrl_props
   import psrc_pkg::*;
   (
   // clock, reset and line
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       clkEn,
   input wire logic       resetPowerOkLineOut,
   input wire logic       resetPowerOkLineOe,
   input wire logic       chipReset,
   // supplies and regulator
   input wire logic       fieldSupplyOk,
   input wire logic       fiveVoltRailOk,
   input wire logic       outAbove95,
   input wire logic       outAbove103,
   input wire logic       regulatorEnable,
   input wire logic [1:0] regulatorMode,
   input wire logic       switchNodeRun,
   input wire logic       switchClk
   );
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // length of the current high phase in enabled cycles
   logic [7:0] hiCnt;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         hiCnt <= 8'h00;
      else if (clkEn)
         hiCnt <= switchClk ? hiCnt + 8'h01 : 8'h00;
   end
   a_sw_half: assert property (
      hiCnt <= 8'(`PSRC_SW_HALF)) else $error("switch phase too long");
   a_pull_only: assert property (
      resetPowerOkLineOe || !resetPowerOkLineOut) else $error("line high");
   a_uv_pull: assert property (!(fieldSupplyOk && fiveVoltRailOk)
      |-> ##[1:4] !resetPowerOkLineOe) else $error("no pull on uv");
   a_out_pull: assert property (regulatorEnable && !outAbove95
      |-> ##[1:4] !resetPowerOkLineOe) else $error("no pull on low out");
   a_pull_resets: assert property (!resetPowerOkLineOe
      |-> ##[0:3] chipReset) else $error("pulled but running");
   a_off_mode: assert property (!regulatorEnable
      |-> regulatorMode == MODE_OFF) else $error("off not shown");
   a_sw_rate: assert property ($rose(switchClk)
      |-> (switchClk || !switchNodeRun)[*8]) else $error("short high");
   a_sw_gate: assert property (!switchNodeRun[*3]
      |-> !switchClk) else $error("clock while stopped");
   a_pfm_stop: assert property (
      (regulatorMode == MODE_PFM && outAbove103)[*6] |-> !switchNodeRun)
      else $error("pfm still switching");
   // main scenarios reached
   c_pulled: cover property (!resetPowerOkLineOe);
   c_pfm_idle: cover property (regulatorMode == MODE_PFM && !switchNodeRun);
   c_switching: cover property ($rose(switchClk));
endmodule : psrc_ctrl_props
// attach to every controller instance
bind psrc_ctrl psrc_ctrl_props psrc_ctrl_props_inst (.clk(clk), .nrst(nrst),
   .clkEn(clkEn),
   .resetPowerOkLineOut(resetPowerOkLineOut), .chipReset(chipReset),
   .resetPowerOkLineOe(resetPowerOkLineOe), .outAbove95(outAbove95),
   .fieldSupplyOk(fieldSupplyOk), .fiveVoltRailOk(fiveVoltRailOk),
   .outAbove103(outAbove103), .regulatorEnable(regulatorEnable),
   .regulatorMode(regulatorMode), .switchNodeRun(switchNodeRun),
   .switchClk(switchClk));

// ===== tb/testbench.sv
// self-checking bench of the regulator controller
`timescale 1ns/10ps
`include "psrc_cfg.svh"
module testbench;
   import psrc_pkg::*;
   localparam int REL = 50;
   logic        clk = 0, nrst = 0, clkEn = 1, hostPull = 1;
   logic        psel = 0, penable = 0, pwrite = 0, rdPend = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, d, q[$];
   logic        fOk = 1, vOk = 1, a95 = 1, a101 = 0, a103 = 0, vmLow = 0;
   logic        pready, pslverr, lineIn, lineOut, lineOe;
   logic        regEn, swRun, swClk, irq, chipRst;
   logic [1:0]  regMode, m;
   logic        qe[$];
   int          n_mismatch = 0, checks = 0;
   // 125 MHz clock
   initial forever #4 clk = ~clk;
   psrc_ctrl #(.REL_CYCLES(REL)) psrc_ctrl_inst (.clk(clk), .nrst(nrst),
      .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .resetPowerOkLineIn(lineIn),
      .resetPowerOkLineOut(lineOut), .resetPowerOkLineOe(lineOe),
      .fieldSupplyOk(fOk), .fiveVoltRailOk(vOk), .outAbove95(a95),
      .outAbove101(a101), .outAbove103(a103), .voltageMonitorLow(vmLow),
      .regulatorEnable(regEn), .regulatorMode(regMode), .chipReset(chipRst),
      .switchNodeRun(swRun), .switchClk(swClk), .irq(irq));
   psrc_host psrc_host_inst (.devOut(lineOut), .devOe(lineOe),
      .hostPull(hostPull), .lineLevel(lineIn));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   // one apb transfer; held until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 40);
      if (n >= 40)
      begin
         n_mismatch++;
         close_out();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : xfer
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      // addresses past the map answer with an error
      qe.push_back(a > `PSRC_OFF_STATUS);
      xfer(1'b0, a, 32'h0);
   endtask : rd
   // bounded wait for chip reset to clear; a hang ends the run
   task automatic settle(input int lim);
      for (int i = 0; i < lim && chipRst !== 1'b0; i++) @(posedge clk);
      if (chipRst !== 1'b0)
      begin
         n_mismatch++;
         close_out();
      end
   endtask : settle
   // read data is registered, so compare one cycle after the access
   always @(posedge clk)
   begin
      if (rdPend && q.size() > 0)
      begin
         chk(prdata, q.pop_front());
         chk(pslverr, qe.pop_front());
      end
      rdPend <= psel && penable && !pwrite && pready;
   end
   initial
   begin
      void'($urandom(22024));
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      xfer(1'b1, `PSRC_OFF_MODE, 32'h7);
      rd(`PSRC_OFF_MODE, 32'h0);
      chk(lineOe, 1'b1);
      chk(chipRst, 1'b1);
      hostPull <= 1'b0;
      settle(8);
      chk(chipRst, 1'b0);
      chk(regEn, 1'b1);
      a95 <= 1'b0;
      repeat (6) @(posedge clk);
      chk(lineIn, 1'b0);
      a95 <= 1'b1;
      settle(REL + 20);
      chk(chipRst, 1'b0);
      $display("test reset done");
      // mode select with random upper bits
      for (int k = 0; k < 4; k++)
      begin
         d = ($urandom & 32'h0000FFF8) | 32'(k << 1);
         m = k[0] ? MODE_DCM : (k[1] ? MODE_PFM : MODE_PWM);
         xfer(1'b1, `PSRC_OFF_MODE, d);
         rd(`PSRC_OFF_MODE, {29'h0, d[2:0]});
         chk(regMode, m);
      end
      xfer(1'b1, `PSRC_OFF_MODE, 32'h4);
      a101 <= 1'b1;
      a103 <= 1'b1;
      repeat (6) @(posedge clk);
      chk(swRun, 1'b0);
      a103 <= 1'b0;
      repeat (6) @(posedge clk);
      chk(swRun, 1'b0);
      a101 <= 1'b0;
      repeat (6) @(posedge clk);
      chk(swRun, 1'b1);
      $display("test modes done");
      // a frozen block must not see the monitor input
      clkEn <= 1'b0;
      vmLow <= 1'b1;
      repeat (6) @(posedge clk);
      chk(irq, 1'b0);
      clkEn <= 1'b1;
      repeat (6) @(posedge clk);
      chk(irq, 1'b1);
      rd(`PSRC_OFF_INT, 32'h1);
      chk(irq, 1'b1);
      xfer(1'b1, `PSRC_OFF_MASK, 32'h1);
      @(posedge clk);
      chk(irq, 1'b0);
      xfer(1'b1, `PSRC_OFF_MASK, 32'h0);
      vmLow <= 1'b0;
      repeat (6) @(posedge clk);
      rd(`PSRC_OFF_INT, 32'h1);
      rd(`PSRC_OFF_INT, 32'h0);
      chk(irq, 1'b0);
      rd(8'h10, 32'h0);
      $display("test interrupt done");
      // outside reset with the regulator disabled
      xfer(1'b1, `PSRC_OFF_MODE, 32'h1);
      hostPull <= 1'b1;
      repeat (8) @(posedge clk);
      chk(chipRst, 1'b1);
      chk(lineOe, 1'b1);
      hostPull <= 1'b0;
      repeat (REL / 2) @(posedge clk);
      chk(lineIn, 1'b0);
      settle(REL + 20);
      chk(chipRst, 1'b0);
      rd(`PSRC_OFF_MODE, 32'h0);
      $display("test external reset done");
      xfer(1'b1, `PSRC_OFF_MODE, 32'h1);
      chk(regEn, 1'b0);
      fOk <= 1'b0;
      a95 <= 1'b0;
      repeat (6) @(posedge clk);
      chk(lineIn, 1'b0);
      fOk <= 1'b1;
      repeat (6) @(posedge clk);
      chk(regMode, MODE_DCM);
      a95 <= 1'b1;
      repeat (REL - 10) @(posedge clk);
      chk(lineIn, 1'b0);
      repeat (22) @(posedge clk);
      chk(lineIn, 1'b1);
      chk(regMode, MODE_PWM);
      $display("test undervoltage done");
      close_out();
   end
endmodule : testbench
